//--- common/sbcs_pkg.sv
// Shared constants and types for the standby and clock-stop control block
package sbcs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int NS_PER_S = 1_000_000_000;
   // Oscillator restart settle time, least time, in ns
   localparam int OSC_SETTLE_NS = 10_000;
   localparam int OSC_SETTLE_CYC =
      (OSC_SETTLE_NS / 1000 * (CLK_HZ / 1_000_000) > 0) ?
      OSC_SETTLE_NS / 1000 * (CLK_HZ / 1_000_000) : 1;
   localparam int SETTLE_W = 16;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_LOW = 1'b0;
   localparam logic RST_HIGH = 1'b1;
   localparam logic MUTE_ON = 1'b1;

   // ----------------------------------------------------------------
   // Run state of oscillator and CPU
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {SBCS_RUN, SBCS_STOP, SBCS_WARM} sbcs_state_type;

endpackage : sbcs_pkg

//--- rtl/sbcs_change_detect.sv
// Level change detector for the radio power sense input
`timescale 1ns/100ps
`default_nettype none

module sbcs_change_detect
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic level,
   output logic change
);

   logic prev_reg;

   // Sense is expected low at power-on, so reset matches it
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         prev_reg <= sbcs_pkg::RST_LOW;
      else
         prev_reg <= level;
   end

   assign change = prev_reg ^ level;

endmodule : sbcs_change_detect
`default_nettype wire

//--- rtl/sbcs_standby_ctrl.sv
// Radio sense, PLL reference gating, clock-stop and system reset control
`timescale 1ns/100ps
`default_nettype none

// Function
// - Radio sense high means radio on, low means radio off.
// - Radio sense low forces the PLL reference output low.
// - Clock-stop with sense low halts oscillator and CPU into back-up.
// - While stopped, PLL reference, port and muting outputs are driven low; portValid keeps its value.
// - While stopped, data memory and port contents are retained.
// - Clock-stop with sense high acts as no-operation; CPU keeps running.
// - Crystal oscillation stays off while clock-stop is in effect.
// - Test input high selects test mode; low or open selects normal.
// - Test input has a pull-down so an open pin means normal.
// - Power-on reset applies system reset, then execution starts at zero.
// - Port contents are undefined after power-up until the program writes; here the port latch resets to zero and portValid stays low.
// - Any radio sense level change drives the muting output high.
// - Initialise input low holds reset; high starts from address zero.
module sbcs_standby_ctrl
#(
   parameter int PORT_W = 8,
   parameter int SETTLE_CYC = sbcs_pkg::OSC_SETTLE_CYC
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic radioPowerSense,
   input wire logic initN,
   input wire logic testPin,
   input wire logic clockStopInstr,
   input wire logic refClkIn,
   input wire logic portWrite,
   input wire logic [PORT_W-1:0] portData,
   input wire logic muteWrite,
   input wire logic muteData,
   output logic cpuReset,
   output logic cpuClkEn,
   output logic crystalPinsRun,
   output logic ramHold,
   output logic testMode,
   output logic radioOn,
   output logic pllRefOut,
   output logic [PORT_W-1:0] portOut,
   output logic portValid,
   output logic muteOut
);

   sbcs_pkg::sbcs_state_type state_reg;
   sbcs_pkg::sbcs_state_type state_next;
   logic [sbcs_pkg::SETTLE_W-1:0] settle_reg;
   logic [PORT_W-1:0] portLatch_reg;
   logic portLoaded_reg;
   logic muteLatch_reg;
   logic senseChange;
   logic runNext;
   logic stopReq;

   // ----------------------------------------------------------------
   // Radio sense edge detection
   // ----------------------------------------------------------------
   sbcs_change_detect u_sense_edge
   (
      .core_clk(core_clk),
      .nrst(nrst),
      .level(radioPowerSense),
      .change(senseChange)
   );

   // ----------------------------------------------------------------
   // Clock-stop state machine
   // ----------------------------------------------------------------
   // Honoured only from a running, out-of-reset CPU
   assign stopReq = clockStopInstr && cpuClkEn && !cpuReset;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         sbcs_pkg::SBCS_RUN:
            if (stopReq && !radioPowerSense)
               state_next = sbcs_pkg::SBCS_STOP;
         sbcs_pkg::SBCS_STOP:
            if (radioPowerSense)
               state_next = sbcs_pkg::SBCS_WARM;
         sbcs_pkg::SBCS_WARM:
            if (settle_reg == sbcs_pkg::SETTLE_W'(SETTLE_CYC - 1))
               state_next = sbcs_pkg::SBCS_RUN;
      endcase
   end

   assign runNext = (state_next == sbcs_pkg::SBCS_RUN);

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         state_reg <= sbcs_pkg::SBCS_RUN;
      else
         state_reg <= state_next;
   end

   // Oscillator settle count, only runs while warming up
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         settle_reg <= '0;
      else if (state_reg == sbcs_pkg::SBCS_WARM)
         settle_reg <= settle_reg + sbcs_pkg::SETTLE_W'(1);
      else
         settle_reg <= '0;
   end

   // ----------------------------------------------------------------
   // Clock, oscillator and memory hold controls
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cpuClkEn <= sbcs_pkg::RST_HIGH;
         crystalPinsRun <= sbcs_pkg::RST_HIGH;
         ramHold <= sbcs_pkg::RST_LOW;
      end
      else
      begin
         cpuClkEn <= runNext;
         crystalPinsRun <= (state_next != sbcs_pkg::SBCS_STOP);
         ramHold <= !runNext;
      end
   end

   // ----------------------------------------------------------------
   // System reset
   // ----------------------------------------------------------------
   // Power-on holds the CPU in reset until the first edge with initN high
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         cpuReset <= sbcs_pkg::RST_HIGH;
      else
         cpuReset <= !initN;
   end

   // ----------------------------------------------------------------
   // Mode inputs
   // ----------------------------------------------------------------
   // Pad pull-down resolves an open pin to low before it reaches here
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         testMode <= sbcs_pkg::RST_LOW;
         radioOn <= sbcs_pkg::RST_LOW;
      end
      else
      begin
         testMode <= testPin;
         radioOn <= radioPowerSense;
      end
   end

   // ----------------------------------------------------------------
   // Output terminals
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         pllRefOut <= sbcs_pkg::RST_LOW;
      else
         pllRefOut <= radioPowerSense && runNext && refClkIn;
   end

   // Port latch survives the stop; only the pins go low
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         portLatch_reg <= '0;
         portLoaded_reg <= sbcs_pkg::RST_LOW;
      end
      else if (portWrite && cpuClkEn && !cpuReset)
      begin
         portLatch_reg <= portData;
         portLoaded_reg <= sbcs_pkg::RST_HIGH;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         portOut <= '0;
         portValid <= sbcs_pkg::RST_LOW;
      end
      else
      begin
         portOut <= runNext ? portLatch_reg : '0;
         portValid <= portLoaded_reg;
      end
   end

   // Sense change wins over a same-cycle program write
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         muteLatch_reg <= sbcs_pkg::RST_LOW;
      else if (senseChange)
         muteLatch_reg <= sbcs_pkg::MUTE_ON;
      else if (muteWrite && cpuClkEn && !cpuReset)
         muteLatch_reg <= muteData;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         muteOut <= sbcs_pkg::RST_LOW;
      else
         muteOut <= runNext && (muteLatch_reg || senseChange);
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence stopIssued;
      clockStopInstr && cpuClkEn && !cpuReset && !radioPowerSense;
   endsequence

   sequence senseReturns;
      state_reg == sbcs_pkg::SBCS_STOP && radioPowerSense;
   endsequence

   ref_gated_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !radioPowerSense |=> !pllRefOut)
      else $error("PLL reference not low with radio off");

   stop_entry_a: assert property (@(posedge core_clk) disable iff (!nrst)
      stopIssued |=> !cpuClkEn && !crystalPinsRun && ramHold)
      else $error("Clock stop did not halt oscillator and CPU");

   stop_outputs_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !cpuClkEn |-> !pllRefOut && portOut == '0 && !muteOut)
      else $error("Output terminal high during back-up");

   port_kept_a: assert property (@(posedge core_clk) disable iff (!nrst)
      stopIssued ##1 (state_reg != sbcs_pkg::SBCS_RUN) [*3]
      |-> portLatch_reg == $past(portLatch_reg, 2))
      else $error("Port contents lost across stop");

   stop_no_operation_instr_a: assert property (@(posedge core_clk) disable iff (!nrst)
      clockStopInstr && cpuClkEn && !cpuReset && radioPowerSense |=> cpuClkEn)
      else $error("Clock stop acted with radio on");

   osc_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
      state_reg == sbcs_pkg::SBCS_STOP && !radioPowerSense |=> !crystalPinsRun)
      else $error("Oscillator running while stopped");

   test_mode_a: assert property (@(posedge core_clk) disable iff (!nrst)
      testMode == $past(testPin))
      else $error("Test mode does not follow test input");

   init_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !initN |=> cpuReset)
      else $error("Reset not held with initialise low");

   mute_edge_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $changed(radioPowerSense) && runNext |=> muteOut)
      else $error("Mute not raised on radio sense change");

   wake_time_a: assert property (@(posedge core_clk) disable iff (!nrst)
      senseReturns |-> ##[1:300] cpuClkEn)
      else $error("CPU did not resume after radio on");

endmodule : sbcs_standby_ctrl
`default_nettype wire

//--- test/sbcs_power_partner.sv
// Radio power switch and supply reset circuit model
`timescale 1ns/100ps
`default_nettype none

module sbcs_power_partner
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic radioReq,
   input wire logic initReq,
   output logic radioPowerSense,
   output logic initN
);
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         radioPowerSense <= 1'h0;
         initN <= 1'h1;
      end
      else
      begin
         radioPowerSense <= radioReq;
         initN <= !initReq;
      end
   end
endmodule : sbcs_power_partner
`default_nettype wire

//--- test/standby_clock_stop_control_tb_top.sv
// Self-checking bench for the standby and clock-stop control block
`timescale 1ns/100ps
`default_nettype none

module standby_clock_stop_control_tb_top;
   logic core_clk = 1'h0;
   logic nrst = 1'h0;
   logic radioReq = 1'h0;
   logic initReq = 1'h0;
   logic testPin = 1'h0;
   logic clockStopInstr = 1'h0;
   logic refClkIn = 1'h0;
   logic portWrite = 1'h0;
   logic [7:0] portData = 8'h00;
   logic muteWrite = 1'h0;
   logic muteData = 1'h0;
   logic radioPowerSense, initN, cpuReset, cpuClkEn, crystalPinsRun, ramHold;
   logic testMode, radioOn, pllRefOut, portValid, muteOut;
   logic [7:0] portOut;
   int n_errors = 0;
   int check_count = 0;

   always #25 core_clk = !core_clk;

   sbcs_power_partner partner (.core_clk(core_clk), .nrst(nrst), .radioReq(radioReq),
      .initReq(initReq), .radioPowerSense(radioPowerSense), .initN(initN));

   // Short settle count keeps the wake-up walk brief
   sbcs_standby_ctrl #(.PORT_W(8), .SETTLE_CYC(4)) dut (.core_clk(core_clk), .nrst(nrst),
      .radioPowerSense(radioPowerSense), .initN(initN), .testPin(testPin),
      .clockStopInstr(clockStopInstr), .refClkIn(refClkIn), .portWrite(portWrite),
      .portData(portData), .muteWrite(muteWrite), .muteData(muteData),
      .cpuReset(cpuReset), .cpuClkEn(cpuClkEn), .crystalPinsRun(crystalPinsRun),
      .ramHold(ramHold), .testMode(testMode), .radioOn(radioOn), .pllRefOut(pllRefOut),
      .portOut(portOut), .portValid(portValid), .muteOut(muteOut));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle

   task automatic pulse_stop;
      @(posedge core_clk);
      clockStopInstr <= 1'h1;
      @(posedge core_clk);
      clockStopInstr <= 1'h0;
   endtask : pulse_stop

   task automatic write_port(input logic [7:0] d);
      @(posedge core_clk);
      portWrite <= 1'h1;
      portData <= d;
      @(posedge core_clk);
      portWrite <= 1'h0;
   endtask : write_port

   task automatic finish_test;
      $display("Checks %0d, errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset;
      check(cpuReset, 1'h1, "reset held");
      check(portValid, 1'h0, "port unwritten");
      @(posedge core_clk);
      nrst <= 1'h1;
      settle(2);
      check(cpuReset, 1'h0, "run from zero");
      @(posedge core_clk);
      initReq <= 1'h1;
      settle(3);
      check(cpuReset, 1'h1, "init held");
      @(posedge core_clk);
      initReq <= 1'h0;
      settle(3);
      check(cpuReset, 1'h0, "init released");
   endtask : test_reset

   task automatic test_ref;
      @(posedge core_clk);
      refClkIn <= 1'h1;
      radioReq <= 1'h1;
      settle(3);
      check(radioOn, 1'h1, "radio on");
      check(pllRefOut, 1'h1, "ref passes");
      check(muteOut, 1'h1, "mute on rise");
      @(posedge core_clk);
      muteWrite <= 1'h1;
      @(posedge core_clk);
      muteWrite <= 1'h0;
      settle(1);
      check(muteOut, 1'h0, "mute cleared");
      @(posedge core_clk);
      radioReq <= 1'h0;
      settle(3);
      check(radioOn, 1'h0, "radio off");
      check(pllRefOut, 1'h0, "ref gated");
      check(muteOut, 1'h1, "mute on fall");
   endtask : test_ref

   task automatic test_stop;
      write_port(8'hA5);
      settle(2);
      check(portOut, 8'hA5, "port written");
      check(portValid, 1'h1, "port valid");
      pulse_stop;
      settle(2);
      check(cpuClkEn, 1'h0, "cpu halted");
      check(ramHold, 1'h1, "memory kept");
      check(crystalPinsRun, 1'h0, "osc stopped");
      check(portOut, 8'h00, "port low");
      check(muteOut, 1'h0, "mute low");
      // Refused while halted, so the latch must still hold the old word
      write_port(8'h3C);
      @(posedge core_clk);
      radioReq <= 1'h1;
      settle(3);
      check(crystalPinsRun, 1'h1, "osc restart");
      check(cpuClkEn, 1'h0, "osc settling");
      for (int i = 0; i < 12 && cpuClkEn !== 1'h1; i++)
         settle(1);
      settle(1);
      check(cpuClkEn, 1'h1, "cpu resumed");
      check(portOut, 8'hA5, "port kept");
      check(muteOut, 1'h1, "mute on wake");
   endtask : test_stop

   task automatic test_no_operation_instr;
      pulse_stop;
      settle(2);
      check(cpuClkEn, 1'h1, "no-op run");
      check(crystalPinsRun, 1'h1, "no-op osc");
      check(pllRefOut, 1'h1, "no-op ref");
   endtask : test_no_operation_instr

   task automatic test_mode;
      @(posedge core_clk);
      testPin <= 1'h1;
      settle(2);
      check(testMode, 1'h1, "test mode");
      @(posedge core_clk);
      testPin <= 1'h0;
      settle(2);
      check(testMode, 1'h0, "normal mode");
   endtask : test_mode

   initial
   begin
      repeat (12) @(posedge core_clk);
      test_reset;
      test_ref;
      test_stop;
      test_no_operation_instr;
      test_mode;
      finish_test;
   end

   initial
   begin
      // Sequence needs under 200 cycles
      repeat (2000) @(posedge core_clk);
      n_errors++;
      finish_test;
   end
endmodule : standby_clock_stop_control_tb_top
`default_nettype wire
